// File: rtl/clk_pll_pkg.sv
// Package for the clock output and PLL start-up block.
// Assumes a single 20 MHz system clock standing in for the crystal input.
package clk_pll_pkg;

  // Clock rate and frequency limit
  localparam int unsigned CLK_FREQ_HZ     = 20000000;
  localparam int unsigned MAX_OUT_FREQ_HZ = 100000000;

  // PLL factor widths and reset values
  localparam int unsigned FACTOR_W        = 4;
  localparam logic [3:0]  MUL_FACTOR_RST  = 4'h1;
  localparam logic [3:0]  DIV_FACTOR_RST  = 4'h1;

  // Control register field positions
  localparam int unsigned PLL_EN_POS      = 0;
  localparam logic        PLL_EN_RST      = 1'b0;

  // Clock source selection
  typedef enum logic [1:0]
  {
    SRC_HALF   = 2'b00,
    SRC_DIRECT = 2'b01,
    SRC_SCALED = 2'b10
  } clk_src_type;

  // PLL configuration carried together
  typedef struct packed
  {
    logic [3:0] mulFactor;
    logic [3:0] divFactor;
  } pll_cfg_type;

  // Clock output status carried together
  typedef struct packed
  {
    logic        pllEnabled;
    clk_src_type source;
    logic        freqValid;
  } clk_status_type;

endpackage : clk_pll_pkg

// File: rtl/clock_output_and_pll_init.sv
// Clock output generation, PLL start-up capture and interrupt request capture.
// Assumes clk is the oscillator clock from crystal or external source.
`timescale 1ns/100ps
module clock_output_and_pll_init
  import clk_pll_pkg::*;
(
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst_n,
  // Start-up and configuration
  input  wire logic           pll_startup_select,
  input  wire pll_cfg_type    pllCfg,
  input  wire logic           extClockMode,
  input  wire logic [31:0]    opFreqHz,
  // Interrupt request pin
  input  wire logic           nmiReq_n,
  // Clock and crystal outputs
  output logic                clock_output,
  output logic                crystal_drive_output,
  output logic                coreClkEn,
  // Status
  output logic                pll_enable_bit,
  output clk_status_type      status,
  output logic                dramAllowed,
  output logic                nmiRequest
);

  // Internal state
  logic        pllEn_reg;
  logic        rstSeen_reg;
  logic        half_reg;
  logic        clock_output_reg;
  logic        crystalDrv_reg;
  logic        dramOk_reg;
  clk_src_type src_next;
  clk_src_type src_reg;
  logic        coreEn;
  logic        freqOk;
  logic        nmiSampleEn;

  // Source decode from the enable bit and both factors
  function automatic clk_src_type decode_source
  (
    input logic        pllOn,
    input pll_cfg_type cfg
  );
    clk_src_type src;
    src = SRC_HALF;
    if (pllOn)
    begin
      if (cfg.mulFactor == MUL_FACTOR_RST && cfg.divFactor == DIV_FACTOR_RST)
      begin
        src = SRC_DIRECT;
      end
      else
      begin
        src = SRC_SCALED;
      end
    end
    return src;
  endfunction : decode_source

  // Frequency limit for memory accesses and the freqValid status only
  function automatic logic freq_in_range
  (
    input logic [31:0] freq
  );
    return (freq <= MAX_OUT_FREQ_HZ);
  endfunction : freq_in_range

  // Start-up pin copied on every edge while reset is held; no
  // asynchronous reset here, so reset must span at least one edge
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pllEn_reg <= pll_startup_select;
    end
  end

  // Marks the first edge after reset release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstSeen_reg <= 1'b0;
    end
    else
    begin
      rstSeen_reg <= 1'b1;
    end
  end

  // Source selection
  always_comb
  begin
    src_next = decode_source(pllEn_reg, pllCfg);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      src_reg <= SRC_HALF;
    end
    else
    begin
      src_reg <= src_next;
    end
  end

  // Half-rate toggle, the core clock enable while the PLL is off
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      half_reg <= 1'b0;
    end
    else
    begin
      half_reg <= ~half_reg;
    end
  end

  // Core clock enable per source
  always_comb
  begin
    unique case (src_reg)
      SRC_HALF:
      begin
        coreEn = half_reg;
      end
      SRC_DIRECT:
      begin
        coreEn = 1'b1;
      end
      SRC_SCALED:
      begin
        coreEn = 1'b1;
      end
      default:
      begin
        coreEn = half_reg;
      end
    endcase
  end

  // Clock output from its own toggle, reset and flipped every edge like
  // half_reg, so the two never drift apart in phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clock_output_reg <= 1'b0;
    end
    else if (src_reg == SRC_HALF)
    begin
      clock_output_reg <= ~clock_output_reg;
    end
    else
    begin
      clock_output_reg <= ~clock_output_reg & coreEn;
    end
  end

  // Crystal drive only when a crystal is fitted
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      crystalDrv_reg <= 1'b0;
    end
    else if (extClockMode)
    begin
      crystalDrv_reg <= 1'b0;
    end
    else
    begin
      crystalDrv_reg <= ~crystalDrv_reg;
    end
  end

  // Frequency limit for memory accesses and the freqValid status
  assign freqOk = freq_in_range(opFreqHz);

  // Memory accesses barred above the limit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dramOk_reg <= 1'b0;
    end
    else
    begin
      dramOk_reg <= freqOk;
    end
  end

  // Interrupt edges only count after reset, on core clock cycles
  assign nmiSampleEn = rstSeen_reg & coreEn;

  nmi_sync u_nmi_sync
  (
    .clk      (clk),
    .rst_n    (rst_n),
    .sampleEn (nmiSampleEn),
    .nmiReq_n (nmiReq_n),
    .nmiPulse (nmiRequest)
  );

  // Outputs
  assign clock_output         = clock_output_reg;
  assign crystal_drive_output = crystalDrv_reg;
  assign coreClkEn            = coreEn;
  assign pll_enable_bit       = pllEn_reg;
  assign dramAllowed          = dramOk_reg;
  assign status               = '{pllEnabled: pllEn_reg, source: src_reg, freqValid: dramOk_reg};

endmodule : clock_output_and_pll_init

// File: rtl/nmi_sync.sv
// Two-stage synchroniser and falling-edge detector for the interrupt request.
// Assumes the request pin may change at any time relative to clk.
`timescale 1ns/100ps
module nmi_sync
  import clk_pll_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Sampling enable and request
  input  wire logic sampleEn,
  input  wire logic nmiReq_n,
  // Request pulse
  output logic      nmiPulse
);

  logic syncA_reg;
  logic syncB_reg;
  logic last_reg;
  logic pulse_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncA_reg <= 1'b1;
      syncB_reg <= 1'b1;
    end
    else
    begin
      syncA_reg <= nmiReq_n;
      syncB_reg <= syncA_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last_reg  <= 1'b1;
      pulse_reg <= 1'b0;
    end
    else
    begin
      pulse_reg <= 1'b0;
      if (sampleEn)
      begin
        last_reg  <= syncB_reg;
        pulse_reg <= last_reg & ~syncB_reg;
      end
    end
  end

  assign nmiPulse = pulse_reg;

endmodule : nmi_sync

// File: tb/clock_output_and_pll_init_bench.sv
// Bench for the clock output block.
// Assumes the source model drives the mode strap.
`timescale 1ns/100ps
module clock_output_and_pll_init_bench
  import clk_pll_pkg::*;
;
  logic           clk = 1'b0, rst_n = 1'b0, pll_startup_select = 1'b0, useExt = 1'b0, nmiReq_n = 1'b1;
  logic [31:0]    opFreqHz = 32'h05F5E100;
  pll_cfg_type    pllCfg = 8'h11;
  logic           extClockMode, clock_output, crystal_drive_output, coreClkEn, pll_enable_bit, dramAllowed, nmiRequest;
  clk_status_type status;
  int             n_fail = 0, cmp_count = 0;
  always #25 clk = ~clk;
  crystal_drive_output_src u_crystal_drive_output_src (.useExt(useExt), .extClockMode(extClockMode));
  clock_output_and_pll_init u_clock_output_and_pll_init
  (
    .clk(clk), .rst_n(rst_n), .pll_startup_select(pll_startup_select), .pllCfg(pllCfg),
    .extClockMode(extClockMode), .opFreqHz(opFreqHz), .nmiReq_n(nmiReq_n), .clock_output(clock_output),
    .crystal_drive_output(crystal_drive_output), .coreClkEn(coreClkEn), .pll_enable_bit(pll_enable_bit),
    .status(status), .dramAllowed(dramAllowed), .nmiRequest(nmiRequest)
  );
  task step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  task chk(input logic ok);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("BAD %0t mismatch", $time);
    end
  endtask : chk
  task finish_test;
    if (n_fail == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task t_start(input logic s);
    logic prev;
    logic prevX;
    rst_n = 1'b0;
    pll_startup_select = s;
    step(3);
    rst_n = 1'b1;
    pll_startup_select = ~s;
    step(3);
    prev = clock_output;
    prevX = crystal_drive_output;
    step(1);
    chk(pll_enable_bit === s && status.pllEnabled === s);
    chk(crystal_drive_output !== prevX);
    if (!s) chk(clock_output !== prev && status.source === SRC_HALF);
    else chk(status.source === SRC_DIRECT);
    if (!s) chk(clock_output === coreClkEn);
  endtask : t_start
  task t_nmi;
    int hits;
    hits = 0;
    nmiReq_n = 1'b0;
    repeat (10)
    begin
      step(1);
      hits += (nmiRequest === 1'b1);
    end
    nmiReq_n = 1'b1;
    chk(hits == 1);
    step(3);
  endtask : t_nmi
  task t_ext;
    useExt = 1'b1;
    pllCfg = 8'h21;
    step(2);
    chk(crystal_drive_output === 1'b0);
    chk(status.source === SRC_SCALED && coreClkEn === 1'b1);
    useExt = 1'b0;
    pllCfg = 8'h11;
  endtask : t_ext
  task t_freq;
    opFreqHz = 32'h05F5E101;
    step(2);
    chk(dramAllowed === 1'b0 && status.freqValid === 1'b0);
    opFreqHz = 32'h05F5E100;
    step(2);
    chk(dramAllowed === 1'b1 && status.freqValid === 1'b1);
  endtask : t_freq
  initial
  begin
    t_start(1'b0);
    t_nmi;
    t_start(1'b1);
    t_nmi;
    t_ext;
    t_freq;
    finish_test;
  end
  initial
  begin
    #20000;
    n_fail++;
    finish_test;
  end
endmodule : clock_output_and_pll_init_bench
bind clock_output_and_pll_init clock_output_and_pll_init_props u_props
(
  .clk(clk), .rst_n(rst_n), .pllCfg(pllCfg), .extClockMode(extClockMode), .opFreqHz(opFreqHz),
  .nmiReq_n(nmiReq_n), .clock_output(clock_output), .crystal_drive_output(crystal_drive_output),
  .coreClkEn(coreClkEn), .pll_enable_bit(pll_enable_bit), .status(status), .dramAllowed(dramAllowed),
  .nmiRequest(nmiRequest)
);

// File: tb/clock_output_and_pll_init_props.sv
// Checker for the clock output block.
// Assumes a bind from the bench top.
`timescale 1ns/100ps
module clock_output_and_pll_init_props
  import clk_pll_pkg::*;
(
  input wire logic           clk,
  input wire logic           rst_n,
  input wire pll_cfg_type    pllCfg,
  input wire logic           extClockMode,
  input wire logic [31:0]    opFreqHz,
  input wire logic           nmiReq_n,
  input wire logic           clock_output,
  input wire logic           crystal_drive_output,
  input wire logic           coreClkEn,
  input wire logic           pll_enable_bit,
  input wire clk_status_type status,
  input wire logic           dramAllowed,
  input wire logic           nmiRequest
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence nmiFall;
    $past(rst_n) && $fell(nmiReq_n) ##1 !nmiReq_n [*2];
  endsequence
  AST_PEN_HOLD: assert property ($past(rst_n) |-> $stable(pll_enable_bit)) else $error("pen");
  AST_HALF_TOG: assert property ($past(rst_n, 2) && !pll_enable_bit |-> clock_output != $past(clock_output))
    else $error("half");
  AST_DIRECT: assert property ($past(rst_n) && $past(pll_enable_bit) && pll_enable_bit && $stable(pllCfg)
    && pllCfg == 8'h11 |-> status.source == SRC_DIRECT) else $error("direct");
  AST_CORE: assert property ($past(rst_n) && $past(pll_enable_bit) && pll_enable_bit |-> coreClkEn)
    else $error("core");
  AST_PHASE: assert property (status.source == SRC_HALF |-> clock_output == coreClkEn) else $error("phase");
  AST_NMI_LAT: assert property (nmiFall |-> ##[1:4] nmiRequest) else $error("nmi");
  AST_NMI_ONE: assert property (nmiRequest |=> !nmiRequest) else $error("pulse");
  AST_FREQ: assert property ($past(rst_n) && $stable(opFreqHz)
    |-> status.freqValid == (opFreqHz <= 32'h05F5E100)) else $error("valid");
  AST_DRAM: assert property ($stable(opFreqHz) && opFreqHz > 32'h05F5E100 |-> !dramAllowed)
    else $error("dram");
  AST_CRYSTAL_DRIVE_OUTPUT: assert property (extClockMode |=> !crystal_drive_output) else $error("crystal_drive_output");
endmodule : clock_output_and_pll_init_props

// File: tb/crystal_drive_output_src.sv
// Crystal or external clock source model.
// Assumes the bench picks the source kind.
`timescale 1ns/100ps
module crystal_drive_output_src
(
  // Selection
  input  wire logic useExt,
  // Mode strap
  output logic      extClockMode
);
  assign extClockMode = useExt;
endmodule : crystal_drive_output_src
